/* hw/dcr_defs.svh */
/*
  Register map, field positions, reset values and serial-port constants
  for the converter control register bank. Included by the register bank and serial port files.
*/
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH

// map size
`define DCR_AW 7
`define DCR_NREG 9

// register offsets
`define DCR_A_RSVD 7'h00
`define DCR_A_RSTPWR 7'h01
`define DCR_A_CLKCTL 7'h02
`define DCR_A_DCKCTL 7'h03
`define DCR_A_PORT 7'h04
`define DCR_A_SYNC 7'h05
`define DCR_A_PHCMP 7'h06
`define DCR_A_LINCTL 7'h07
`define DCR_A_LINV 7'h08

// field positions
`define DCR_B_SOFT_RST 0
`define DCR_B_CORE_PD 1
`define DCR_B_FULL_POWER_DOWN 2
`define DCR_B_CK_OFF 0
`define DCR_B_SAMPLE_CLOCK_PRESENT 1
`define DCR_B_DCKO_OFF 4
`define DCR_B_DCKO_RATIO 5
`define DCR_B_DCKO_DRIVE 6
`define DCR_B_DCKO_TERM 7
`define DCR_B_DATA_CLOCK_RX_ENABLE 0
`define DCR_B_DATA_CLOCK_PRESENT 1
`define DCR_B_DCKI_QUAD 2
`define DCR_B_PORT_A 0
`define DCR_B_PORT_B 1
`define DCR_B_SINGLE 2
`define DCR_B_DATA_EN 3
`define DCR_B_SYNC_MAN 2
`define DCR_B_LINEARIZER_DISABLE 0

// writable bits per register
`define DCR_M_RSTPWR 8'h06
`define DCR_M_CLKCTL 8'hF1
`define DCR_M_DCKCTL 8'h75
`define DCR_M_PORT 8'h0F
`define DCR_M_SYNC 8'h07
`define DCR_M_LINCTL 8'h0F
`define DCR_M_LINV 8'hFF

// reset values
`define DCR_R_ZERO 8'h00
`define DCR_R_LINV 8'h08

// serial port: instruction bit 7 high means read
`define DCR_SPI_LAST_INSTR 5'h07
`define DCR_SPI_FIRST_DATA 5'h08
`define DCR_SPI_LAST_DATA 5'h0F

`endif

/* hw/dcr_pkg.sv */
/*
  Types shared by the control register bank files.
  Assumes nothing of its surroundings.
*/
package dcr_pkg;
  typedef enum logic [2:0] {
    SPI_IDLE = 3'b001,
    SPI_INSTR = 3'b010,
    SPI_DATA = 3'b100
  } dcr_spi_state_t;
endpackage

/* hw/dcr_regbank.sv */
/*
  Control and status register bank of the converter, addresses 0x00-linearization_voltage_limits,
  reached over the serial port. Assumes status inputs come from other clock
  domains and the analog core acts on the control levels driven here.
*/
`timescale 1ns/1ps
`include "dcr_defs.svh"
`default_nettype none

// Summary of operation
// RULE1: soft reset bit restores all defaults
// RULE2: core power down bit powers down core
// RULE3: full power down bit powers down device
// RULE4: resolution reads default when powered down
// RULE5: clock control bit0 turns sample receiver off
// RULE6: clock present flag reads detector state
// RULE7: bit4 disables divided clock output driver
// RULE8: bit5 selects divide by four or two
// RULE9: bit6 selects low or high drive
// RULE10: bit7 enables divided output termination
// RULE11: data clock receiver enable, off at reset
// RULE12: data clock present flag reads detector
// RULE13: bit2 selects in phase or quadrature
// RULE14: three bit data clock delay trim
// RULE15: port A and B receiver enables
// RULE16: bit2 selects dual or single port
// RULE17: data enable clear forces mid scale
// RULE18: manual bit picks host phase, else automatic
// RULE19: phase comparator outputs readable, zero at reset
// RULE20: linearizer disable bit, enabled at reset
// RULE21: three bit linearizer gain, zero reset
// RULE22: voltage limits, max resets 1000, min zero
// RULE23: host waits before setting data enable
// RULE24: reserved bits read zero, ignore writes
module dcr_regbank #(
  // converter variant code, value arbitrary
  parameter logic [1:0] RES_CODE = 2'h2,
  parameter int PHCMP_W = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // serial port pins
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  // asynchronous status inputs
  input wire logic i_power_down_pin_n,
  input wire logic i_sample_clock_present,
  input wire logic i_data_clock_present,
  input wire logic [1:0] i_sync_phase_auto,
  input wire logic [PHCMP_W-1:0] i_phase_comparator_out,
  // power control
  output logic o_core_power_down,
  output logic o_full_power_down,
  // sample clock and divided output
  output logic o_sample_clock_rx_off,
  output logic o_divided_clock_out_off,
  output logic o_divided_clock_ratio,
  output logic o_divided_clock_drive_sel,
  output logic o_divided_clock_termination,
  // data clock receiver
  output logic o_data_clock_rx_enable,
  output logic o_data_clock_quadrature,
  output logic [2:0] o_data_clock_delay_trim,
  // data ports
  output logic o_port_a_rx_enable,
  output logic o_port_b_rx_enable,
  output logic o_single_port_select,
  output logic o_force_midscale,
  // synchronizer
  output logic [1:0] o_sync_phase_select,
  // linearizer
  output logic o_linearizer_disable,
  output logic [2:0] o_linearizer_gain,
  output logic [3:0] o_linearizer_max_voltage,
  output logic [3:0] o_linearizer_min_voltage
);
  localparam int NSYNC = PHCMP_W + 5;
  localparam logic [7:0] WMASK [0:`DCR_NREG-1] = '{
    `DCR_R_ZERO, `DCR_M_RSTPWR, `DCR_M_CLKCTL, `DCR_M_DCKCTL, `DCR_M_PORT,
    `DCR_M_SYNC, `DCR_R_ZERO, `DCR_M_LINCTL, `DCR_M_LINV};
  localparam logic [7:0] RSTV [0:`DCR_NREG-1] = '{
    `DCR_R_ZERO, `DCR_R_ZERO, `DCR_R_ZERO, `DCR_R_ZERO, `DCR_R_ZERO,
    `DCR_R_ZERO, `DCR_R_ZERO, `DCR_R_ZERO, `DCR_R_LINV};

  logic [`DCR_AW-1:0] s_addr;
  logic s_wr;
  logic [7:0] s_wdata;
  logic [7:0] rd_data;
  logic soft_rst;
  logic [7:0] regs_r [0:`DCR_NREG-1];
  logic [NSYNC-1:0] st_m_r;
  logic [NSYNC-1:0] st_s_r;
  logic pd_n_s;
  logic sample_clock_present_s;
  logic dck_ok_s;
  logic [1:0] phase_auto_s;
  logic [PHCMP_W-1:0] phcmp_s;
  logic [1:0] res_r;
  logic res_done_r;

  dcr_spi_slave u_spi (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_sck(i_sck),
    .i_cs_n(i_cs_n),
    .i_sdi(i_sdi),
    .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe),
    .o_addr(s_addr),
    .o_wr(s_wr),
    .o_wdata(s_wdata),
    .i_rdata(rd_data)
  );

  // status pins from other domains, two flops each; the phase bits are
  // quasi-static, so a skewed multi-bit sample only lasts a cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_m_r <= '0;
      st_s_r <= '0;
    end else begin
      st_m_r <= {i_phase_comparator_out, i_sync_phase_auto, i_data_clock_present,
                 i_sample_clock_present, i_power_down_pin_n};
      st_s_r <= st_m_r;
    end
  end

  assign pd_n_s = st_s_r[0];
  assign sample_clock_present_s = st_s_r[1]; // RULE6
  assign dck_ok_s = st_s_r[2]; // RULE12
  assign phase_auto_s = st_s_r[4:3];
  assign phcmp_s = st_s_r[NSYNC-1:5]; // RULE19

  // variant code latched once after reset release
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      res_r <= 2'h0;
      res_done_r <= 1'b0;
    end else if (!res_done_r) begin
      res_r <= RES_CODE;
      res_done_r <= 1'b1;
    end
  end

  assign soft_rst = s_wr && s_addr == `DCR_A_RSTPWR && s_wdata[`DCR_B_SOFT_RST]; // RULE1

  // soft reset bit is never stored, so it reads back zero
  genvar k;
  generate
    for (k = 0; k < `DCR_NREG; k++) begin : g_reg
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          regs_r[k] <= RSTV[k];
        end else if (soft_rst) begin
          regs_r[k] <= RSTV[k]; // RULE1
        end else if (s_wr && s_addr == `DCR_AW'(k)) begin
          regs_r[k] <= s_wdata & WMASK[k]; // RULE24
        end
      end
    end
  endgenerate

  // control levels straight from the register flops
  assign o_core_power_down = regs_r[1][`DCR_B_CORE_PD]; // RULE2
  assign o_full_power_down = regs_r[1][`DCR_B_FULL_POWER_DOWN]; // RULE3
  assign o_sample_clock_rx_off = regs_r[2][`DCR_B_CK_OFF]; // RULE5
  assign o_divided_clock_out_off = regs_r[2][`DCR_B_DCKO_OFF]; // RULE7
  assign o_divided_clock_ratio = regs_r[2][`DCR_B_DCKO_RATIO]; // RULE8
  assign o_divided_clock_drive_sel = regs_r[2][`DCR_B_DCKO_DRIVE]; // RULE9
  assign o_divided_clock_termination = regs_r[2][`DCR_B_DCKO_TERM]; // RULE10
  assign o_data_clock_rx_enable = regs_r[3][`DCR_B_DATA_CLOCK_RX_ENABLE]; // RULE11
  assign o_data_clock_quadrature = regs_r[3][`DCR_B_DCKI_QUAD]; // RULE13
  assign o_data_clock_delay_trim = regs_r[3][6:4]; // RULE14
  assign o_port_a_rx_enable = regs_r[4][`DCR_B_PORT_A]; // RULE15
  assign o_port_b_rx_enable = regs_r[4][`DCR_B_PORT_B]; // RULE15
  assign o_single_port_select = regs_r[4][`DCR_B_SINGLE]; // RULE16
  assign o_linearizer_disable = regs_r[7][`DCR_B_LINEARIZER_DISABLE]; // RULE20
  assign o_linearizer_gain = regs_r[7][3:1]; // RULE21
  assign o_linearizer_max_voltage = regs_r[8][3:0]; // RULE22
  assign o_linearizer_min_voltage = regs_r[8][7:4]; // RULE22

  // mid-scale hold; the host must let the synchronizer settle before data enable
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_force_midscale <= 1'b1;
    end else begin
      o_force_midscale <= ~regs_r[4][`DCR_B_DATA_EN]; // RULE17 RULE23
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sync_phase_select <= 2'h0;
    end else if (regs_r[5][`DCR_B_SYNC_MAN]) begin
      o_sync_phase_select <= regs_r[5][1:0]; // RULE18
    end else begin
      o_sync_phase_select <= phase_auto_s; // RULE18
    end
  end

  // read mux; the serial front end samples it on the first SCK fall after the address
  always_comb begin
    rd_data = 8'h00; // RULE24
    unique case (s_addr)
      `DCR_A_RSTPWR: begin
        rd_data = regs_r[1];
        if (pd_n_s && !regs_r[1][`DCR_B_FULL_POWER_DOWN]) begin
          rd_data[5:4] = res_r; // RULE4
        end
      end
      `DCR_A_CLKCTL: rd_data = regs_r[2] | {6'h00, sample_clock_present_s, 1'b0}; // RULE6
      `DCR_A_DCKCTL: rd_data = regs_r[3] | {6'h00, dck_ok_s, 1'b0}; // RULE12
      `DCR_A_PORT: rd_data = regs_r[4];
      `DCR_A_SYNC: rd_data = {regs_r[5][7:2], o_sync_phase_select}; // RULE18
      `DCR_A_PHCMP: rd_data = 8'(phcmp_s); // RULE19
      `DCR_A_LINCTL: rd_data = regs_r[7];
      `DCR_A_LINV: rd_data = regs_r[8];
      default: rd_data = 8'h00;
    endcase
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence wr_s(logic [`DCR_AW-1:0] a);
    s_wr && s_addr == a;
  endsequence

  sequence plain_wr_s(logic [`DCR_AW-1:0] a);
    wr_s(a) ##0 !(a == `DCR_A_RSTPWR && s_wdata[`DCR_B_SOFT_RST]);
  endsequence

  soft_reset_a: assert property ( // RULE1
    wr_s(`DCR_A_RSTPWR) ##0 s_wdata[`DCR_B_SOFT_RST] |=>
      regs_r[1] == 8'h00 && regs_r[2] == 8'h00 && regs_r[4] == 8'h00 &&
      o_linearizer_max_voltage == 4'h8 && o_linearizer_min_voltage == 4'h0)
    else $error("soft reset left a register off its default");

  core_pd_a: assert property ( // RULE2
    plain_wr_s(`DCR_A_RSTPWR) |=> o_core_power_down == $past(s_wdata[1]))
    else $error("core power down does not follow write");

  full_power_down_a: assert property ( // RULE3
    plain_wr_s(`DCR_A_RSTPWR) |=> o_full_power_down == $past(s_wdata[2]))
    else $error("full power down does not follow write");

  res_gate_a: assert property ( // RULE4
    s_addr == `DCR_A_RSTPWR && (!pd_n_s || o_full_power_down) |-> rd_data[5:4] == 2'h0)
    else $error("resolution not default while powered down");

  res_code_a: assert property ( // RULE4
    s_addr == `DCR_A_RSTPWR && pd_n_s && !o_full_power_down && res_done_r |->
      rd_data[5:4] == RES_CODE && rd_data[0] == 1'b0)
    else $error("resolution code wrong while powered up");

  ck_rx_a: assert property ( // RULE5
    plain_wr_s(`DCR_A_CLKCTL) |=> o_sample_clock_rx_off == $past(s_wdata[0]) &&
      o_divided_clock_ratio == $past(s_wdata[5]))
    else $error("clock control not applied");

  ck_flag_a: assert property ( // RULE6
    $rose(i_sample_clock_present) ##2 s_addr == `DCR_A_CLKCTL |-> rd_data[1])
    else $error("sample clock present flag late");

  dck_rx_a: assert property ( // RULE11
    plain_wr_s(`DCR_A_DCKCTL) |=> o_data_clock_rx_enable == $past(s_wdata[0]) &&
      o_data_clock_delay_trim == $past(s_wdata[6:4]))
    else $error("data clock control not applied");

  midscale_a: assert property ( // RULE17
    plain_wr_s(`DCR_A_PORT) ##0 !s_wdata[3] |=> ##1 o_force_midscale)
    else $error("mid-scale not forced after data disable");

  phase_man_a: assert property ( // RULE18
    regs_r[5][2] [*2] |-> o_sync_phase_select == $past(regs_r[5][1:0]))
    else $error("manual phase not used");

  phase_auto_a: assert property ( // RULE18
    !regs_r[5][2] [*2] |-> o_sync_phase_select == $past(phase_auto_s))
    else $error("automatic phase not used");

  rsvd_rd_a: assert property ( // RULE24
    s_addr == `DCR_A_RSVD || s_addr > `DCR_A_LINV |-> rd_data == 8'h00)
    else $error("reserved address reads nonzero");

  rsvd_wr_a: assert property ( // RULE24
    plain_wr_s(`DCR_A_PORT) |=> regs_r[4][7:4] == 4'h0)
    else $error("reserved bits took a write");

  // field checks; each written control shows up the clock after the write, data enable one clock later
  ck_out_a: assert property ( // RULE7
    plain_wr_s(`DCR_A_CLKCTL) |=> o_divided_clock_out_off == $past(s_wdata[4]))
    else $error("divided clock disable not applied");

  ck_drive_a: assert property ( // RULE9
    plain_wr_s(`DCR_A_CLKCTL) |=> o_divided_clock_drive_sel == $past(s_wdata[6]))
    else $error("divided clock drive select not applied");

  ck_term_a: assert property ( // RULE10
    plain_wr_s(`DCR_A_CLKCTL) |=> o_divided_clock_termination == $past(s_wdata[7]))
    else $error("divided clock termination not applied");

  // a detector edge needs both synchroniser flops before the read mux sees it
  ck_gone_a: assert property ( // RULE6
    $fell(i_sample_clock_present) ##2 s_addr == `DCR_A_CLKCTL |-> !rd_data[1])
    else $error("sample clock present flag stuck");

  dck_flag_a: assert property ( // RULE12
    $rose(i_data_clock_present) ##2 s_addr == `DCR_A_DCKCTL |-> rd_data[1])
    else $error("data clock present flag late");

  dck_gone_a: assert property ( // RULE12
    $fell(i_data_clock_present) ##2 s_addr == `DCR_A_DCKCTL |-> !rd_data[1])
    else $error("data clock present flag stuck");

  dck_quad_a: assert property ( // RULE13
    plain_wr_s(`DCR_A_DCKCTL) |=> o_data_clock_quadrature == $past(s_wdata[2]))
    else $error("data clock phase select not applied");

  port_en_a: assert property ( // RULE15
    plain_wr_s(`DCR_A_PORT) |=>
      o_port_a_rx_enable == $past(s_wdata[0]) && o_port_b_rx_enable == $past(s_wdata[1]))
    else $error("port receiver enables not applied");

  port_mode_a: assert property ( // RULE16
    plain_wr_s(`DCR_A_PORT) |=> o_single_port_select == $past(s_wdata[2]))
    else $error("port mode not applied");

  data_en_a: assert property ( // RULE17
    plain_wr_s(`DCR_A_PORT) ##0 s_wdata[3] |=> ##1 !o_force_midscale)
    else $error("mid-scale still forced after data enable");

  // comparator word read back once it has been steady through both flops
  phcmp_rd_a: assert property ( // RULE19
    $stable(i_phase_comparator_out) [*3] ##0 s_addr == `DCR_A_PHCMP |->
      rd_data == 8'(i_phase_comparator_out))
    else $error("phase comparator read differs from pins");

  lin_ctl_a: assert property ( // RULE20 RULE21
    plain_wr_s(`DCR_A_LINCTL) |=>
      o_linearizer_disable == $past(s_wdata[0]) && o_linearizer_gain == $past(s_wdata[3:1]))
    else $error("linearizer control not applied");

  lin_volt_a: assert property ( // RULE22
    plain_wr_s(`DCR_A_LINV) |=>
      o_linearizer_max_voltage == $past(s_wdata[3:0]) &&
      o_linearizer_min_voltage == $past(s_wdata[7:4]))
    else $error("linearizer voltage limits not applied");

  soft_bit_a: assert property ( // RULE1 RULE24
    wr_s(`DCR_A_RSTPWR) |=> !regs_r[1][`DCR_B_SOFT_RST] && regs_r[1][7:3] == 5'h00)
    else $error("soft reset or reserved bit stored");
endmodule // dcr_regbank

`default_nettype wire

/* hw/dcr_spi_slave.sv */
/*
  Serial port front end: mode-0 SPI slave, instruction byte then data bytes.
  Assumes SCK, CS and SDI are asynchronous pins and SCK runs at most i_clk/8.
*/
`timescale 1ns/1ps
`include "dcr_defs.svh"
`default_nettype none

module dcr_spi_slave (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // serial pins
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  // register side
  output logic [`DCR_AW-1:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  logic [2:0] pin_m_r;
  logic [2:0] pin_s_r;
  logic sck_d_r;
  logic sck_rise;
  logic sck_fall;
  logic cs_off;
  dcr_pkg::dcr_spi_state_t state_r;
  logic [4:0] cnt_r;
  logic [7:0] sh_r;
  logic rd_r;
  logic [7:0] tx_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_m_r <= 3'h1;
      pin_s_r <= 3'h1;
      sck_d_r <= 1'b0;
    end else begin
      pin_m_r <= {i_sdi, i_sck, i_cs_n};
      pin_s_r <= pin_m_r;
      sck_d_r <= pin_s_r[1];
    end
  end

  assign cs_off = pin_s_r[0];
  assign sck_rise = pin_s_r[1] & ~sck_d_r;
  assign sck_fall = ~pin_s_r[1] & sck_d_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= dcr_pkg::SPI_IDLE;
    end else if (cs_off) begin
      state_r <= dcr_pkg::SPI_IDLE;
    end else begin
      unique case (state_r)
        dcr_pkg::SPI_IDLE: state_r <= dcr_pkg::SPI_INSTR;
        dcr_pkg::SPI_INSTR: begin
          if (sck_rise && cnt_r == `DCR_SPI_LAST_INSTR) begin
            state_r <= dcr_pkg::SPI_DATA;
          end
        end
        dcr_pkg::SPI_DATA: state_r <= dcr_pkg::SPI_DATA;
      endcase
    end
  end

  // further bytes in one frame reuse the same address
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= 5'h00;
      sh_r <= 8'h00;
    end else if (cs_off || state_r == dcr_pkg::SPI_IDLE) begin
      cnt_r <= 5'h00;
    end else if (sck_rise) begin
      cnt_r <= (cnt_r == `DCR_SPI_LAST_DATA) ? `DCR_SPI_FIRST_DATA : cnt_r + 5'h01;
      sh_r <= {sh_r[6:0], pin_s_r[2]};
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_r <= 1'b0;
      o_addr <= `DCR_A_RSVD;
    end else if (sck_rise && state_r == dcr_pkg::SPI_INSTR && cnt_r == `DCR_SPI_LAST_INSTR) begin
      rd_r <= sh_r[6];
      o_addr <= {sh_r[5:0], pin_s_r[2]};
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wr <= 1'b0;
      o_wdata <= 8'h00;
    end else begin
      o_wr <= sck_rise && !cs_off && state_r == dcr_pkg::SPI_DATA && !rd_r &&
              cnt_r == `DCR_SPI_LAST_DATA;
      if (sck_rise && cnt_r == `DCR_SPI_LAST_DATA) begin
        o_wdata <= {sh_r[6:0], pin_s_r[2]};
      end
    end
  end

  // read data shifts out on falling edges, msb first
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sdo <= 1'b0;
      o_sdo_oe <= 1'b0;
      tx_r <= 8'h00;
    end else begin
      o_sdo_oe <= !cs_off && state_r == dcr_pkg::SPI_DATA && rd_r;
      if (sck_fall && state_r == dcr_pkg::SPI_DATA && rd_r) begin
        if (cnt_r == `DCR_SPI_FIRST_DATA) begin
          o_sdo <= i_rdata[7];
          tx_r <= {i_rdata[6:0], 1'b0};
        end else begin
          o_sdo <= tx_r[7];
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end
endmodule // dcr_spi_slave

`default_nettype wire

/* verif/dcr_spi_host.sv */
/*
  Host side serial port model: mode-0 master, MSB first, instruction then data.
  Assumes the bench resolves the data-out wire and that i_clk runs at 100 MHz.
*/
`timescale 1ns/1ps
`default_nettype none

module dcr_spi_host (
  // clock
  input wire logic i_clk,
  // serial pins
  input wire logic i_sdo_line,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_sdi
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // half period of 6 clocks keeps above the 4 clock floor of the port
  task automatic frame(input logic [7:0] instr, input logic [7:0] data, input int nbits,
                       output logic [7:0] rdata);
    logic [15:0] sh;
    sh = {instr, data};
    rdata = 8'h00;
    wait_clk(1);
    o_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_sdi = sh[15-i];
      wait_clk(6);
      if (i >= 8) rdata = {rdata[6:0], i_sdo_line};
      o_sck = 1'b1;
      wait_clk(6);
      o_sck = 1'b0;
    end
    wait_clk(6);
    o_cs_n = 1'b1;
    // released line must not keep showing the last bit
    o_sdi = ~o_sdi;
    wait_clk(6);
  endtask
endmodule // dcr_spi_host

`default_nettype wire

/* verif/test_dac_control_register_bank.sv */
/*
  Self-checking bench of the register bank: random writes and reads over the
  serial port, soft reset, cut frames, start-up order. Assumes the host model.
*/
`timescale 1ns/1ps
`include "dcr_defs.svh"
`default_nettype none

module test_dac_control_register_bank;
  // variant code, value arbitrary
  localparam logic [1:0] RES_V = 2'h2;
  logic clk, rstn, sck, cs_n, sdi, sdo, sdo_oe, sdo_line, toggle_r;
  logic pin_n, sample_clock_present, dck_ok, core_pd, full_power_down, ck_off, dco_off, dco_ratio, dco_drive;
  logic dco_term, dck_en, dck_quad, port_a, port_b, single, midscale, linearizer_disable;
  logic [1:0] ph_auto, ph_sel;
  logic [2:0] dck_trim, lin_gain;
  logic [3:0] vmax, vmin;
  logic [7:0] phcmp, rsp;
  logic [7:0] shadow [0:8];
  logic [31:0] seed, r;
  int failures, checks_done;

  // undriven data-out wire shows a changing pattern, never a stale bit
  assign sdo_line = sdo_oe ? sdo : toggle_r;

  dcr_spi_host host (.i_clk(clk), .i_sdo_line(sdo_line), .o_sck(sck), .o_cs_n(cs_n),
    .o_sdi(sdi));

  dcr_regbank #(.RES_CODE(RES_V), .PHCMP_W(8)) dut (
    .i_clk(clk), .i_rstn(rstn), .i_sck(sck), .i_cs_n(cs_n), .i_sdi(sdi),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_power_down_pin_n(pin_n),
    .i_sample_clock_present(sample_clock_present), .i_data_clock_present(dck_ok),
    .i_sync_phase_auto(ph_auto), .i_phase_comparator_out(phcmp),
    .o_core_power_down(core_pd), .o_full_power_down(full_power_down),
    .o_sample_clock_rx_off(ck_off), .o_divided_clock_out_off(dco_off),
    .o_divided_clock_ratio(dco_ratio), .o_divided_clock_drive_sel(dco_drive),
    .o_divided_clock_termination(dco_term), .o_data_clock_rx_enable(dck_en),
    .o_data_clock_quadrature(dck_quad), .o_data_clock_delay_trim(dck_trim),
    .o_port_a_rx_enable(port_a), .o_port_b_rx_enable(port_b),
    .o_single_port_select(single), .o_force_midscale(midscale),
    .o_sync_phase_select(ph_sel), .o_linearizer_disable(linearizer_disable),
    .o_linearizer_gain(lin_gain), .o_linearizer_max_voltage(vmax),
    .o_linearizer_min_voltage(vmin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) toggle_r <= (toggle_r !== 1'b1);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] mask(input logic [3:0] a);
    case (a)
      4'h1: return `DCR_M_RSTPWR;
      4'h2: return `DCR_M_CLKCTL;
      4'h3: return `DCR_M_DCKCTL;
      4'h4: return `DCR_M_PORT;
      4'h5: return `DCR_M_SYNC;
      4'h7: return `DCR_M_LINCTL;
      4'h8: return `DCR_M_LINV;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] exp_read(input logic [6:0] a);
    logic [7:0] v;
    v = (a <= 7'h08) ? shadow[a[3:0]] : 8'h00;
    if (a == `DCR_A_RSTPWR && pin_n && !shadow[1][`DCR_B_FULL_POWER_DOWN]) v[5:4] = RES_V;
    if (a == `DCR_A_CLKCTL) v[`DCR_B_SAMPLE_CLOCK_PRESENT] = sample_clock_present;
    if (a == `DCR_A_DCKCTL) v[`DCR_B_DATA_CLOCK_PRESENT] = dck_ok;
    if (a == `DCR_A_SYNC && !shadow[5][`DCR_B_SYNC_MAN]) v[1:0] = ph_auto;
    if (a == `DCR_A_PHCMP) v = phcmp;
    return v;
  endfunction

  task automatic set_defaults();
    for (int i = 0; i < 9; i++) shadow[i] = `DCR_R_ZERO;
    shadow[8] = `DCR_R_LINV;
  endtask

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.frame({1'b0, a}, d, 16, rsp);
    if (a == `DCR_A_RSTPWR && d[`DCR_B_SOFT_RST]) set_defaults();
    else if (a <= 7'h08) shadow[a[3:0]] = d & mask(a[3:0]);
  endtask

  task automatic rd_check(input logic [6:0] a);
    host.frame({1'b1, a}, 8'h00, 16, rsp);
    check($sformatf("register %0h", a), {24'h0, exp_read(a)}, {24'h0, rsp});
  endtask

  task automatic check_outputs();
    logic [29:0] e;
    e = {shadow[1][2:1], shadow[2][0], shadow[2][7:4], shadow[3][0], shadow[3][2],
         shadow[3][6:4], shadow[4][2:0], ~shadow[4][3],
         shadow[5][2] ? shadow[5][1:0] : ph_auto, shadow[7][3:0], shadow[8]};
    check("control outputs", {2'b0, e}, {2'b0, full_power_down, core_pd, ck_off, dco_term, dco_drive,
          dco_ratio, dco_off, dck_en, dck_quad, dck_trim, single, port_b, port_a, midscale,
          ph_sel, lin_gain, linearizer_disable, vmin, vmax});
  endtask

  task automatic new_status();
    r = rnd();
    pin_n = r[0] | r[1];
    sample_clock_present = r[2];
    dck_ok = r[3];
    ph_auto = r[5:4];
    phcmp = r[15:8];
    // let the two-flop synchronisers settle
    repeat (4) @(negedge clk);
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    complete_run();
  end

  initial begin
    seed = 32'h234D;
    failures = 0;
    checks_done = 0;
    rstn = 1'b0;
    pin_n = 1'b1;
    {sample_clock_present, dck_ok, ph_auto, phcmp} = 12'h000;
    set_defaults();
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    check_outputs();
    for (int a = 0; a < 10; a++) rd_check(7'(a));
    rd_check(7'h7F);
    for (int a = 1; a < 10; a++) wr(7'(a), 8'hFE);
    check_outputs();
    for (int a = 0; a < 9; a++) rd_check(7'(a));
    wr(`DCR_A_RSTPWR, 8'h07);
    check_outputs();
    rd_check(`DCR_A_LINV);
    // frame cut after 12 bits must leave the port register alone
    host.frame({1'b0, `DCR_A_PORT}, 8'h0F, 12, rsp);
    check_outputs();
    for (int n = 0; n < 60; n++) begin
      new_status();
      r = rnd();
      wr((r[3:0] > 4'h9) ? 7'h7F : 7'(r[3:0]), r[15:8]);
      check_outputs();
      rd_check(7'(r[3:0] % 4'h9));
      rd_check(7'(r[19:16] % 4'h9));
    end
    wr(`DCR_A_DCKCTL, 8'h05);
    wr(`DCR_A_PORT, 8'h06);
    // shortened settling wait, the bank itself does not enforce it
    repeat (2000) @(negedge clk);
    wr(`DCR_A_PORT, 8'h0E);
    check_outputs();
    complete_run();
  end
endmodule // test_dac_control_register_bank

`default_nettype wire
